//--- rtl/hpsq_pkg.sv
// Package for the headphone, charge pump and sequencer control register bank.
// Assumes a 16-bit register word and an 8-bit register address on the control port.
// Function
// - Output shorted until short-release bit set
// - Output-stage bit enables output stage
// - Intermediate-stage bit enables intermediate stage
// - Input-stage bit enables input stage
// - Secondary volume 1 dB steps, reset 111
// - Boost bias 000 double, 011 unity
// - Pump mode: volume or level tracking
// - Auto-sequence bit drives speaker auto-mute
// - Abort write stops sequence immediately
// - Launch runs from start index until end
// - Launch bit self-clears at sequence end
// - Writes refused while sequencer busy, except abort writes
// - Busy flag and last index readable
`default_nettype none
package hpsq_pkg;
    localparam int unsigned REG_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned IDX_W = 7;
    localparam int unsigned RAM_ADDR_W = 16;

    localparam logic [ADDR_W-1:0] OFS_STAGE = 8'h45;
    localparam logic [ADDR_W-1:0] OFS_VOLBIAS = 8'h47;
    localparam logic [ADDR_W-1:0] OFS_PUMP_EN = 8'h48;
    localparam logic [ADDR_W-1:0] OFS_PUMP_MODE = 8'h52;
    localparam logic [ADDR_W-1:0] OFS_SEQ_EN = 8'h57;
    localparam logic [ADDR_W-1:0] OFS_SEQ_LAUNCH = 8'h5a;
    localparam logic [ADDR_W-1:0] OFS_SEQ_STATUS = 8'h5d;

    // Stage enable bit positions, left then right
    localparam int unsigned B_L_SHORT = 7;
    localparam int unsigned B_L_OUT = 6;
    localparam int unsigned B_L_MID = 5;
    localparam int unsigned B_L_IN = 4;
    localparam int unsigned B_R_SHORT = 3;
    localparam int unsigned B_R_OUT = 2;
    localparam int unsigned B_R_MID = 1;
    localparam int unsigned B_R_IN = 0;
    // Volume and bias fields
    localparam int unsigned B_L_VOL = 6;
    localparam int unsigned B_R_VOL = 3;
    localparam int unsigned B_BIAS = 0;
    localparam logic [2:0] VOL_RESET = 3'h7;
    localparam logic [2:0] BIAS_DOUBLE = 3'h0;
    localparam logic [2:0] BIAS_UNITY = 3'h3;
    // Pump and sequencer bits
    localparam int unsigned B_PUMP_ON = 0;
    localparam int unsigned B_PUMP_TRACK = 0;
    localparam int unsigned B_AUTO_SEQ = 7;
    localparam int unsigned B_SEQ_ON = 5;
    localparam int unsigned B_ABORT = 8;
    localparam int unsigned B_LAUNCH = 7;
    localparam int unsigned B_FIRST_IDX = 0;
    localparam int unsigned B_LAST_IDX = 3;
    localparam int unsigned B_BUSY = 0;
    // Sequencer RAM register mapping
    localparam logic [RAM_ADDR_W-1:0] SEQ_RAM_BASE = 16'h1000;
    localparam int unsigned SEQ_RAM_SHIFT = 2;

    typedef struct packed {
        logic short_release;
        logic output_stage_en;
        logic mid_stage_en;
        logic input_stage_en;
    } hpsq_chan_t;

    typedef enum logic {
        HPSQ_IDLE,
        HPSQ_RUN
    } hpsq_state_t;
endpackage : hpsq_pkg
`default_nettype wire

//--- rtl/hpsq_regs.sv
// Control register bank: headphone stages, volume and bias, charge pump, write sequencer.
// Assumes the serial control front end presents one-cycle read and write strobes on clk.
`timescale 1ns/1ps
`default_nettype none
module hpsq_regs
    import hpsq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [REG_W-1:0] wr_data,
    output logic [REG_W-1:0] rd_data,
    output logic wr_refused,
    output hpsq_chan_t left_hp,
    output hpsq_chan_t right_hp,
    output logic [2:0] left_hp_secondary_volume,
    output logic [2:0] right_hp_secondary_volume,
    output logic [2:0] driver_boost_bias,
    output logic charge_pump_on,
    output logic pump_level_tracking,
    input wire logic hp_volume_update,
    output logic auto_sequence_on,
    output logic sequencer_running_flag,
    output logic [RAM_ADDR_W-1:0] seq_ram_addr,
    input wire logic seq_cmd_done,
    input wire logic seq_cmd_last
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [7:0] stage_bits;
    logic [2:0] bias_field;
    logic pump_track_bit;
    logic sequencer_on;
    logic sequence_launch;
    logic [IDX_W-1:0] sequence_first_index;
    logic [IDX_W-1:0] sequence_last_index;
    hpsq_state_t state;

    logic wr_hit;
    logic launch_req;
    logic abort_req;
    logic seq_stop;
    logic seq_end;

    function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        is_reg = (a == ofs);
    endfunction : is_reg

    // Writes are refused while a sequence runs, except the abort bit
    assign wr_hit = wr_en && (state == HPSQ_IDLE);
    assign abort_req = wr_en && is_reg(addr, OFS_SEQ_LAUNCH) && wr_data[B_ABORT];
    assign launch_req = wr_hit && is_reg(addr, OFS_SEQ_LAUNCH) && wr_data[B_LAUNCH]
        && sequencer_on && !wr_data[B_ABORT];
    assign seq_stop = abort_req || !sequencer_on;
    assign seq_end = seq_cmd_done && seq_cmd_last;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_refused <= 1'b0;
        end else begin
            wr_refused <= wr_en && (state != HPSQ_IDLE) && !abort_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Headphone stage enables and volume/bias

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage_bits <= 8'h00;
        end else if (wr_hit && is_reg(addr, OFS_STAGE)) begin
            stage_bits <= wr_data[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left_hp <= '0;
            right_hp <= '0;
        end else begin
            left_hp.short_release <= stage_bits[B_L_SHORT];
            right_hp.short_release <= stage_bits[B_R_SHORT];
            left_hp.output_stage_en <= stage_bits[B_L_OUT];
            right_hp.output_stage_en <= stage_bits[B_R_OUT];
            left_hp.mid_stage_en <= stage_bits[B_L_MID];
            right_hp.mid_stage_en <= stage_bits[B_R_MID];
            left_hp.input_stage_en <= stage_bits[B_L_IN];
            right_hp.input_stage_en <= stage_bits[B_R_IN];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            left_hp_secondary_volume <= VOL_RESET;
            right_hp_secondary_volume <= VOL_RESET;
            bias_field <= BIAS_UNITY;
        end else if (wr_hit && is_reg(addr, OFS_VOLBIAS)) begin
            left_hp_secondary_volume <= wr_data[B_L_VOL +: 3];
            right_hp_secondary_volume <= wr_data[B_R_VOL +: 3];
            bias_field <= wr_data[B_BIAS +: 3];
        end
    end

    // Only the two defined bias codes reach the driver; reserved codes hold unity
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            driver_boost_bias <= BIAS_UNITY;
        end else begin
            driver_boost_bias <= (bias_field == BIAS_DOUBLE) ? BIAS_DOUBLE : BIAS_UNITY;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Charge pump

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            charge_pump_on <= 1'b0;
        end else if (wr_hit && is_reg(addr, OFS_PUMP_EN)) begin
            charge_pump_on <= wr_data[B_PUMP_ON];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pump_track_bit <= 1'b0;
        end else if (wr_hit && is_reg(addr, OFS_PUMP_MODE)) begin
            pump_track_bit <= wr_data[B_PUMP_TRACK];
        end
    end

    // Tracking starts at once; return to volume control waits for a volume update
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pump_level_tracking <= 1'b0;
        end else if (pump_track_bit) begin
            pump_level_tracking <= 1'b1;
        end else if (hp_volume_update) begin
            pump_level_tracking <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer control

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            auto_sequence_on <= 1'b0;
            sequencer_on <= 1'b0;
        end else if (wr_hit && is_reg(addr, OFS_SEQ_EN)) begin
            auto_sequence_on <= wr_data[B_AUTO_SEQ];
            sequencer_on <= wr_data[B_SEQ_ON];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sequence_first_index <= '0;
        end else if (wr_hit && is_reg(addr, OFS_SEQ_LAUNCH)) begin
            sequence_first_index <= wr_data[B_FIRST_IDX +: IDX_W];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= HPSQ_IDLE;
            sequence_launch <= 1'b0;
            sequence_last_index <= '0;
        end else begin
            case (state)
                HPSQ_IDLE: begin
                    if (launch_req) begin
                        state <= HPSQ_RUN;
                        sequence_launch <= 1'b1;
                        sequence_last_index <= wr_data[B_FIRST_IDX +: IDX_W];
                    end
                end
                HPSQ_RUN: begin
                    if (seq_stop || seq_end) begin
                        state <= HPSQ_IDLE;
                        sequence_launch <= 1'b0;
                    end else if (seq_cmd_done) begin
                        sequence_last_index <= sequence_last_index + 1'b1;
                    end
                end
                default: begin
                    state <= HPSQ_IDLE;
                    sequence_launch <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sequencer_running_flag <= 1'b0;
            seq_ram_addr <= SEQ_RAM_BASE;
        end else begin
            sequencer_running_flag <= (state == HPSQ_RUN) && !seq_stop && !seq_end;
            seq_ram_addr <= SEQ_RAM_BASE
                + (RAM_ADDR_W'(sequence_last_index) << SEQ_RAM_SHIFT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read-back

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= '0;
            case (addr)
                OFS_STAGE: rd_data[7:0] <= stage_bits;
                OFS_VOLBIAS: begin
                    rd_data[B_L_VOL +: 3] <= left_hp_secondary_volume;
                    rd_data[B_R_VOL +: 3] <= right_hp_secondary_volume;
                    rd_data[B_BIAS +: 3] <= bias_field;
                end
                OFS_PUMP_EN: rd_data[B_PUMP_ON] <= charge_pump_on;
                OFS_PUMP_MODE: rd_data[B_PUMP_TRACK] <= pump_track_bit;
                OFS_SEQ_EN: begin
                    rd_data[B_AUTO_SEQ] <= auto_sequence_on;
                    rd_data[B_SEQ_ON] <= sequencer_on;
                end
                OFS_SEQ_LAUNCH: begin
                    rd_data[B_LAUNCH] <= sequence_launch;
                    rd_data[B_FIRST_IDX +: IDX_W] <= sequence_first_index;
                end
                OFS_SEQ_STATUS: begin
                    rd_data[B_LAST_IDX +: IDX_W] <= sequence_last_index;
                    rd_data[B_BUSY] <= (state == HPSQ_RUN);
                end
                default: rd_data <= '0;
            endcase
        end
    end

endmodule : hpsq_regs
`default_nettype wire

//--- test/hpsq_regs_assertions.sv
// Checker for the headphone, pump and sequencer register bank.
// Assumes it is bound to hpsq_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module hpsq_regs_checker
    import hpsq_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [REG_W-1:0] wr_data,
    input wire logic wr_refused,
    input wire hpsq_chan_t left_hp,
    input wire hpsq_chan_t right_hp,
    input wire logic [2:0] left_hp_secondary_volume,
    input wire logic [2:0] right_hp_secondary_volume,
    input wire logic [2:0] driver_boost_bias,
    input wire logic pump_level_tracking,
    input wire logic hp_volume_update,
    input wire logic auto_sequence_on,
    input wire logic sequencer_running_flag,
    input wire logic [RAM_ADDR_W-1:0] seq_ram_addr,
    input wire logic seq_cmd_done,
    input wire logic seq_cmd_last
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Write taken and not refused
    sequence s_take(logic [ADDR_W-1:0] a);
        wr_en && addr == a ##1 !wr_refused;
    endsequence
////////////////////////////////////////
    a_stage_follow: assert property (
        s_take(OFS_STAGE) |-> ##1 {left_hp, right_hp} == $past(wr_data[7:0], 2))
        else $error("stage enables differ from write");
    a_volume_follow: assert property (
        s_take(OFS_VOLBIAS) |-> ##1
        {left_hp_secondary_volume, right_hp_secondary_volume} == $past(wr_data[8:3], 2))
        else $error("volume differs from write");
    a_bias_map: assert property (
        s_take(OFS_VOLBIAS) |-> ##1
        driver_boost_bias == ($past(wr_data[2:0], 2) == 3'h0 ? 3'h0 : 3'h3))
        else $error("boost bias wrong");
    a_track_set: assert property (
        s_take(OFS_PUMP_MODE) ##0 $past(wr_data[0]) |-> ##1 pump_level_tracking)
        else $error("level tracking not set");
    a_track_fall: assert property (
        $fell(pump_level_tracking) |-> $past(hp_volume_update) || $past(hp_volume_update, 2))
        else $error("tracking dropped without update");
    a_auto_follow: assert property (
        s_take(OFS_SEQ_EN) |-> ##1 auto_sequence_on == $past(wr_data[7], 2))
        else $error("auto sequence differs from write");
    a_abort_stop: assert property (
        wr_en && addr == OFS_SEQ_LAUNCH && wr_data[8] && sequencer_running_flag
        |-> ##[1:2] !sequencer_running_flag)
        else $error("abort did not stop sequence");
    a_launch_start: assert property (
        $rose(sequencer_running_flag) |-> $past(wr_en, 2) && $past(addr, 2) == OFS_SEQ_LAUNCH
        && seq_ram_addr[8:2] == $past(wr_data[6:0], 2))
        else $error("sequence start wrong");
    a_index_step: assert property (
        seq_cmd_done && !seq_cmd_last && sequencer_running_flag
        |-> ##2 seq_ram_addr[8:2] == $past(seq_ram_addr[8:2], 2) + 7'h01)
        else $error("index did not advance");
    a_end_drop: assert property (
        seq_cmd_done && seq_cmd_last && sequencer_running_flag
        |-> ##[1:2] !sequencer_running_flag)
        else $error("sequence did not end");
    a_addr_base: assert property (
        seq_ram_addr[15:9] == 7'h08 && seq_ram_addr[1:0] == 2'h0)
        else $error("ram address outside map");
    a_refuse_cause: assert property (
        wr_refused |-> $past(wr_en) && (sequencer_running_flag || $past(sequencer_running_flag)))
        else $error("refusal without busy write");
endmodule : hpsq_regs_checker

bind hpsq_regs hpsq_regs_checker i_hpsq_regs_checker (
    .clk(clk), .rst(rst), .wr_en(wr_en), .addr(addr), .wr_data(wr_data),
    .wr_refused(wr_refused), .left_hp(left_hp), .right_hp(right_hp),
    .left_hp_secondary_volume(left_hp_secondary_volume),
    .right_hp_secondary_volume(right_hp_secondary_volume),
    .driver_boost_bias(driver_boost_bias), .pump_level_tracking(pump_level_tracking),
    .hp_volume_update(hp_volume_update), .auto_sequence_on(auto_sequence_on),
    .sequencer_running_flag(sequencer_running_flag), .seq_ram_addr(seq_ram_addr),
    .seq_cmd_done(seq_cmd_done), .seq_cmd_last(seq_cmd_last)
);
`default_nettype wire

//--- test/hpsq_ram_model.sv
// Sequencer RAM stand-in: answers each command after DELAY plus one busy cycles.
// Assumes the bank's clock, reset, busy flag and RAM address.
`timescale 1ns/1ps
`default_nettype none
module hpsq_ram_model
    import hpsq_pkg::*;
#(
    parameter logic [7:0] DELAY = 8'h08
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic busy,
    input wire logic [RAM_ADDR_W-1:0] ram_addr,
    input wire logic [IDX_W-1:0] end_index,
    output logic cmd_done,
    output logic cmd_last
);
    logic [7:0] cnt;
    logic hit;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 8'h00;
            cmd_done <= 1'b0;
        end else begin
            cnt <= (busy && cnt != DELAY) ? cnt + 8'h01 : 8'h00;
            cmd_done <= busy && cnt == DELAY;
        end
    end
    // End flag at one index; line not held between answers
    assign hit = ram_addr == SEQ_RAM_BASE + {7'h00, end_index, 2'h0};
    assign cmd_last = cmd_done ? hit : ~hit;
endmodule : hpsq_ram_model
`default_nettype wire

//--- test/hpsq_regs_bench.sv
// Bench for the headphone, pump and sequencer register bank.
// Assumes the bank, its bound checker and the RAM stand-in.
`timescale 1ns/1ps
`default_nettype none
module hpsq_regs_bench
    import hpsq_pkg::*;
;
    logic clk, rst, wr_en, rd_en, hp_volume_update, wr_refused, charge_pump_on;
    logic pump_level_tracking, auto_sequence_on, sequencer_running_flag, seq_cmd_done;
    logic seq_cmd_last;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wr_data, rd_data, v;
    hpsq_chan_t left_hp, right_hp;
    logic [2:0] lvol, rvol, bias;
    logic [RAM_ADDR_W-1:0] seq_ram_addr;
    logic [IDX_W-1:0] end_index;
    logic [7:0] stage_seq [4] = '{8'h11, 8'h33, 8'h77, 8'hff};
    logic [7:0] zero_regs [6] = '{8'h45, 8'h48, 8'h52, 8'h57, 8'h5a, 8'h5d};
    int failures, comparisons, cycles, refusals;
    hpsq_regs i_hpsq_regs (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data), .wr_refused(wr_refused), .left_hp(left_hp),
        .right_hp(right_hp), .left_hp_secondary_volume(lvol), .right_hp_secondary_volume(rvol),
        .driver_boost_bias(bias), .charge_pump_on(charge_pump_on),
        .pump_level_tracking(pump_level_tracking), .hp_volume_update(hp_volume_update),
        .auto_sequence_on(auto_sequence_on), .sequencer_running_flag(sequencer_running_flag),
        .seq_ram_addr(seq_ram_addr), .seq_cmd_done(seq_cmd_done), .seq_cmd_last(seq_cmd_last));
    hpsq_ram_model i_hpsq_ram_model (.clk(clk), .rst(rst), .busy(sequencer_running_flag),
        .ram_addr(seq_ram_addr), .end_index(end_index), .cmd_done(seq_cmd_done),
        .cmd_last(seq_cmd_last));
////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        step(1);
        wr_en = 1'b1;
        addr = a;
        wr_data = d;
        step(1);
        wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        step(1);
        rd_en = 1'b1;
        addr = a;
        step(1);
        rd_en = 1'b0;
        step(1);
        chk(rd_data, exp);
    endtask : rd
    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Ceiling well above the 20 us wait and the sequences
    always @(posedge clk) begin
        cycles++;
        if (wr_refused === 1'b1) refusals++;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        rst = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wr_data = 16'h0000;
        hp_volume_update = 1'b0;
        end_index = 7'h00;
        step(5);
        rst = 1'b0;
        foreach (zero_regs[i]) rd(zero_regs[i], 16'h0000);
        rd(OFS_VOLBIAS, 16'h01fb);
        rd(8'h46, 16'h0000);
        $display("test reset done");
        foreach (stage_seq[i]) begin
            wr(OFS_STAGE, {8'h00, stage_seq[i]});
            if (i == 0) step(2000);
            step(2);
            chk({left_hp, right_hp}, stage_seq[i]);
        end
        $display("test stages done");
        for (int i = 0; i < 8; i++) begin
            v = {7'h00, i[2:0], ~i[2:0], (i[0] ? 3'h3 : 3'h0)};
            wr(OFS_VOLBIAS, v);
            step(2);
            chk({lvol, rvol, bias}, v[8:0]);
            rd(OFS_VOLBIAS, v);
        end
        wr(OFS_PUMP_EN, 16'h0001);
        wr(OFS_PUMP_MODE, 16'h0001);
        step(2);
        chk({charge_pump_on, pump_level_tracking}, 2'h3);
        wr(OFS_PUMP_MODE, 16'h0000);
        step(4);
        chk(pump_level_tracking, 1'b1);
        hp_volume_update = 1'b1;
        step(1);
        hp_volume_update = 1'b0;
        step(1);
        chk(pump_level_tracking, 1'b0);
        $display("test volume and pump done");
        wr(OFS_SEQ_EN, 16'h0080);
        wr(OFS_SEQ_LAUNCH, 16'h0085);
        step(2);
        chk({auto_sequence_on, sequencer_running_flag}, 2'h2);
        rd(OFS_SEQ_LAUNCH, 16'h0005);
        wr(OFS_SEQ_EN, 16'h00a0);
        end_index = 7'h01;
        wr(OFS_SEQ_LAUNCH, 16'h00ff);
        rd(OFS_SEQ_STATUS, 16'h03f9);
        rd(OFS_SEQ_LAUNCH, 16'h00ff);
        chk(seq_ram_addr, 16'h11fc);
        for (int i = 0; i < 200 && sequencer_running_flag !== 1'b0; i++) step(1);
        chk(sequencer_running_flag, 1'b0);
        rd(OFS_SEQ_LAUNCH, 16'h007f);
        $display("test sequence done");
        end_index = 7'h0f;
        wr(OFS_SEQ_LAUNCH, 16'h0090);
        step(2);
        wr(OFS_STAGE, 16'h0000);
        step(1);
        chk(refusals[15:0], 16'h0001);
        rd(OFS_STAGE, 16'h00ff);
        wr(OFS_SEQ_LAUNCH, 16'h0110);
        step(2);
        chk(sequencer_running_flag, 1'b0);
        rd(OFS_SEQ_LAUNCH, 16'h0010);
        wr(OFS_STAGE, 16'h0000);
        step(2);
        chk({left_hp, right_hp}, 8'h00);
        $display("test abort done");
        test_done();
    end
endmodule : hpsq_regs_bench
`default_nettype wire
